// ==== logic/watchdog_with_reset_flags.sv ====
/*
 * Watchdog timer with timed change sequence and reset-cause flags, APB slave.
 * Assumes the reset sources arrive as pins from outside the clock domain and
 * that the restart instruction arrives as a one-cycle pulse on clk.
 */
// Decided for this implementation: register access over APB and the address map.
// Functional notes
// - Watchdog counter advances on a 1 MHz tick divided down from the bus clock.
// - Counter clears on restart, while disabled, and on any chip reset.
// - Selected timeout elapsing while enabled causes a device reset.
// - Fuse selects level 1 (initially disabled) or level 2 (always enabled).
// - Timeout code 0 gives 16K ticks, doubling per code to 2048K at 7.
// - At level 1 enable may be set at any time without a sequence.
// - At level 2 enable reads one and can never be cleared.
// - At level 2 the second write changes timeout only; enable value ignored.
// - Change-enable clears itself four clock cycles after being written one together with enable.
// - Enable clears only while change-enable is one.
// - Timeout select changes only while change-enable is set.
// - Control layout: change-enable bit 4, enable bit 3, timeout 2:0, 7:5 zero.
// - Scan flag set by scan-chain reset, cleared by power-on or writing zero.
// - Watchdog flag set by watchdog reset, cleared by power-on or writing zero.
// - Brown-out flag set by brown-out reset, cleared by power-on or writing zero.
// - Pin flag set by external reset, cleared by power-on or writing zero.
// - Power-on flag set by power-on, cleared only by writing zero.
// - Watchdog expiry issues a one-cycle internal reset pulse.
`timescale 1ns/10ps

module watchdog_with_reset_flags (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic alwaysOnFuse,
    input wire logic restartPulse,
    input wire logic poweronReset,
    input wire logic pinReset,
    input wire logic brownoutReset,
    input wire logic scanReset,
    output logic wdogResetPulse
);

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic [4:0] srcMeta_reg;
    logic [4:0] srcSync_reg;
    logic [4:0] srcPrev_reg;
    logic fuseLevel2;
    logic poweronSync;
    logic [4:0] srcRise;

    always_ff @(posedge clk) begin
        if (srst) begin
            srcMeta_reg <= 5'h00;
            srcSync_reg <= 5'h00;
            srcPrev_reg <= 5'h00;
        end else begin
            srcMeta_reg <= {scanReset, brownoutReset, pinReset, poweronReset, alwaysOnFuse};
            srcSync_reg <= srcMeta_reg;
            srcPrev_reg <= srcSync_reg;
        end
    end

    assign fuseLevel2 = srcSync_reg[0];
    assign poweronSync = srcSync_reg[1];
    assign srcRise = srcSync_reg & ~srcPrev_reg;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    logic apbAccess;
    logic hitCause;
    logic hitControl;
    logic hitStatus;
    logic wrCause;
    logic wrControl;

    assign apbAccess = psel && penable;
    assign hitCause = (paddr == watchdog_pkg::RESET_CAUSE_STATUS_OFFSET);
    assign hitControl = (paddr == watchdog_pkg::WATCHDOG_CONTROL_OFFSET);
    assign hitStatus = (paddr == watchdog_pkg::WATCHDOG_STATUS_OFFSET);
    assign wrCause = apbAccess && pwrite && hitCause;
    assign wrControl = apbAccess && pwrite && hitControl;

    // ------------------------------------------------------------------
    // Control register and change window
    // ------------------------------------------------------------------
    logic enable_reg;
    logic [2:0] timeoutSel_reg;
    logic [2:0] windowCnt_reg;
    logic changeEnable;
    logic wrCe;
    logic wrEn;
    logic enableEff;
    logic chipReset;

    assign wrCe = pwdata[watchdog_pkg::CHANGE_ENABLE_POS];
    assign wrEn = pwdata[watchdog_pkg::WDOG_ENABLE_POS];
    assign changeEnable = (windowCnt_reg != 3'h0);
    assign enableEff = enable_reg || fuseLevel2;

    // The window counts down the cycles left after change-enable and enable are written one together.
    always_ff @(posedge clk) begin
        if (srst || chipReset) begin
            windowCnt_reg <= 3'h0;
        end else if (wrControl && wrCe && wrEn) begin
            windowCnt_reg <= 3'(watchdog_pkg::CHANGE_WINDOW_CYCLES);
        end else if (changeEnable) begin
            windowCnt_reg <= windowCnt_reg - 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || chipReset) begin
            enable_reg <= 1'b0;
        end else if (wrControl) begin
            if (wrEn) begin
                enable_reg <= 1'b1;
            end else if (changeEnable && !wrCe) begin
                enable_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst || chipReset) begin
            timeoutSel_reg <= watchdog_pkg::TIMEOUT_SEL_RESET;
        end else if (wrControl && changeEnable && !wrCe) begin
            timeoutSel_reg <= pwdata[watchdog_pkg::TIMEOUT_SEL_MSB:0];
        end
    end

    // ------------------------------------------------------------------
    // Watchdog tick divider and counter
    // ------------------------------------------------------------------
    logic [5:0] divCnt_reg;
    logic oscTick;
    logic [watchdog_pkg::COUNT_WIDTH-1:0] count_reg;
    logic [watchdog_pkg::COUNT_WIDTH-1:0] limit;
    logic expire;

    assign oscTick = (divCnt_reg == 6'(watchdog_pkg::OSC_DIV_CYCLES - 1));
    assign limit = watchdog_pkg::COUNT_WIDTH'(watchdog_pkg::BASE_TIMEOUT_TICKS)
        << timeoutSel_reg;
    assign expire = enableEff && oscTick && (count_reg >= limit - 1'b1);

    always_ff @(posedge clk) begin
        if (srst) begin
            divCnt_reg <= 6'h00;
        end else if (oscTick) begin
            divCnt_reg <= 6'h00;
        end else begin
            divCnt_reg <= divCnt_reg + 6'h01;
        end
    end

    // Counter shares the bus clock, so new settings apply whole on one edge.
    always_ff @(posedge clk) begin
        if (srst || chipReset || restartPulse || !enableEff) begin
            count_reg <= '0;
        end else if (oscTick) begin
            count_reg <= count_reg + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Reset pulse and reset-cause flags
    // ------------------------------------------------------------------
    logic [4:0] cause_reg;
    logic [4:0] causeSet;
    logic [4:0] causeNext;

    always_ff @(posedge clk) begin
        if (srst) begin
            wdogResetPulse <= 1'b0;
        end else begin
            wdogResetPulse <= expire;
        end
    end

    assign chipReset = wdogResetPulse || (|srcRise[4:1]);
    assign causeSet = {srcRise[4], wdogResetPulse, srcRise[3], srcRise[2], srcRise[1]};

    // Each flag keeps its value on a written one and clears on a written zero.
    // A set event in the same cycle as a clearing write wins.
    genvar flagIdx;
    generate
        for (flagIdx = 0; flagIdx < 5; flagIdx++) begin : g_cause
            assign causeNext[flagIdx] = causeSet[flagIdx]
                || (cause_reg[flagIdx] && !(wrCause && !pwdata[flagIdx]));
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (srst) begin
            cause_reg <= watchdog_pkg::RESET_CAUSE_RESET;
        end else if (poweronSync) begin
            cause_reg <= 5'h01;
        end else begin
            cause_reg <= causeNext;
        end
    end

    // ------------------------------------------------------------------
    // APB read path
    // ------------------------------------------------------------------
    logic [31:0] readData;

    always_comb begin
        readData = 32'h0000_0000;
        if (hitCause) begin
            readData[4:0] = cause_reg;
        end else if (hitControl) begin
            readData[watchdog_pkg::CHANGE_ENABLE_POS] = changeEnable;
            readData[watchdog_pkg::WDOG_ENABLE_POS] = enableEff;
            readData[watchdog_pkg::TIMEOUT_SEL_MSB:0] = timeoutSel_reg;
        end else if (hitStatus) begin
            readData[watchdog_pkg::COUNT_WIDTH-1:0] = count_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !(hitCause || hitControl || hitStatus);
            prdata <= (psel && !penable && !pwrite) ? readData : 32'h0000_0000;
        end
    end

endmodule : watchdog_with_reset_flags

// ==== logic/watchdog_pkg.sv ====
/*
 * Constants for the watchdog with reset-cause flags: register offsets,
 * control field positions, timeout table and change-window timing.
 * Assumes a 40 MHz system clock and a nominal 1 MHz watchdog oscillator.
 */
package watchdog_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] RESET_CAUSE_STATUS_OFFSET = 8'h00;
    localparam logic [7:0] WATCHDOG_CONTROL_OFFSET = 8'h04;
    localparam logic [7:0] WATCHDOG_STATUS_OFFSET = 8'h08;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CHANGE_ENABLE_POS = 4;
    localparam int WDOG_ENABLE_POS = 3;
    localparam int TIMEOUT_SEL_MSB = 2;
    localparam int SCAN_FLAG_POS = 4;
    localparam int WDOG_FLAG_POS = 3;
    localparam int BROWNOUT_FLAG_POS = 2;
    localparam int PIN_FLAG_POS = 1;
    localparam int POWERON_FLAG_POS = 0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [2:0] TIMEOUT_SEL_RESET = 3'h0;
    localparam logic [4:0] RESET_CAUSE_RESET = 5'h00;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_FREQ_HZ = 40000000;
    localparam int WDOG_OSC_FREQ_HZ = 1000000;
    localparam int CHANGE_WINDOW_CYCLES = 4;
    localparam int WDOG_PULSE_CYCLES = 1;
    localparam int OSC_DIV_CYCLES = CLK_FREQ_HZ / WDOG_OSC_FREQ_HZ;
    localparam int BASE_TIMEOUT_TICKS = 16384;
    localparam int COUNT_WIDTH = 22;

endpackage : watchdog_pkg

// ==== tb/watchdog_with_reset_flags_sva.sv ====
/*
 * Checker for the watchdog block: APB answer timing, register layout and reset pulse.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/10ps
module watchdog_with_reset_flags_sva (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic alwaysOnFuse,
    input wire logic wdogResetPulse
);
    logic rdCtl;
    assign rdCtl = pready && !pwrite && paddr == 8'h04;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    property p_ready_after_setup; psel && !penable |=> pready; endproperty
    property p_ready_pulse; pready |=> !pready; endproperty
    property p_rdata_idle; !pready |-> prdata == 32'h0; endproperty
    property p_err_with_ready; pslverr |-> pready; endproperty
    property p_err_unmapped; pready && paddr > 8'h08 |-> pslverr; endproperty
    property p_wdog_pulse; wdogResetPulse |=> !wdogResetPulse; endproperty
    property p_reserved; rdCtl |-> prdata[31:5] == 27'h0; endproperty
    property p_level2_on; rdCtl && alwaysOnFuse && $past(alwaysOnFuse, 3) |-> prdata[3]; endproperty
    a_ready_after_setup: assert property (p_ready_after_setup) else $error("no answer");
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
    a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero");
    a_err_with_ready: assert property (p_err_with_ready) else $error("stray pslverr");
    a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped not refused");
    a_wdog_pulse: assert property (p_wdog_pulse) else $error("reset pulse too long");
    a_reserved: assert property (p_reserved) else $error("reserved bits set");
    a_level2_on: assert property (p_level2_on) else $error("enable reads zero");
    c_level2: cover property (rdCtl && alwaysOnFuse && prdata[3]);
    c_unmapped: cover property (pslverr);
    c_window: cover property (rdCtl && prdata[4]);
endmodule : watchdog_with_reset_flags_sva

bind watchdog_with_reset_flags watchdog_with_reset_flags_sva u_watchdog_with_reset_flags_sva (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .alwaysOnFuse(alwaysOnFuse),
    .wdogResetPulse(wdogResetPulse));

// ==== tb/watchdog_with_reset_flags_tb.sv ====
/*
 * Self-checking bench for the watchdog block: reset flags, change window, safety levels.
 * Assumes the APB slave answers by itself; every wait is bounded.
 */
`timescale 1ns/10ps
module watchdog_with_reset_flags_tb;
    logic clk, srst, psel, penable, pwrite, pready, pslverr, fuse, restart, wdogPulse, rerr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdata, rng, exp;
    logic [4:0] srcs;
    int bad_count, comparisons;
    int srcPos[3] = '{1, 2, 4};

    watchdog_with_reset_flags u_watchdog_with_reset_flags (
        .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .alwaysOnFuse(fuse), .restartPulse(restart), .poweronReset(srcs[0]),
        .pinReset(srcs[1]), .brownoutReset(srcs[2]), .scanReset(srcs[4]),
        .wdogResetPulse(wdogPulse));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic conclude();
        $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        comparisons++;
        if (got !== want) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            bad_count++;
            conclude();
        end
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] want);
        apb(1'b0, a, 32'h0);
        chk(rdata, want);
    endtask : rd

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        repeat (100000) @(posedge clk);
        bad_count++;
        conclude();
    end

    initial begin
        {srst, psel, penable, pwrite, fuse, restart} = 6'h20;
        paddr = 8'h00;
        pwdata = 32'h0;
        srcs = 5'h01;
        rng = 32'hF73D;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        repeat (6) @(posedge clk);
        srcs <= 5'h00;
        repeat (4) @(posedge clk);
        rd(8'h00, 32'h01);
        apb(1'b1, 8'h00, 32'hFF);
        rd(8'h00, 32'h01);
        apb(1'b1, 8'h00, 32'h00);
        rd(8'h00, 32'h00);
        exp = 32'h0;
        foreach (srcPos[i]) begin
            srcs[srcPos[i]] <= 1'b1;
            repeat (6) @(posedge clk);
            srcs[srcPos[i]] <= 1'b0;
            repeat (6) @(posedge clk);
            exp[srcPos[i]] = 1'b1;
            rd(8'h00, exp);
        end
        repeat (4) begin
            rng = xs(rng);
            apb(1'b1, 8'h00, rng);
            exp = exp & {27'h0, rng[4:0]};
            rd(8'h00, exp);
        end
        rd(8'h04, 32'h00);
        apb(1'b1, 8'h04, {29'h1, rng[7:5]});
        rd(8'h04, 32'h08);
        apb(1'b1, 8'h04, 32'h00);
        rd(8'h04, 32'h08);
        apb(1'b1, 8'h04, 32'h18);
        rd(8'h04, 32'h18);
        rd(8'h04, 32'h08);
        apb(1'b1, 8'h04, 32'h18);
        apb(1'b1, 8'h04, {29'h0, rng[7:5]});
        rd(8'h04, {29'h0, rng[7:5]});
        rd(8'h0C, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        fuse <= 1'b1;
        restart <= 1'b1;
        @(posedge clk);
        restart <= 1'b0;
        repeat (4) @(posedge clk);
        rd(8'h04, {29'h1, rng[7:5]});
        apb(1'b1, 8'h04, 32'h18);
        apb(1'b1, 8'h04, 32'h02);
        rd(8'h04, 32'h0A);
        restart <= 1'b1;
        @(posedge clk);
        restart <= 1'b0;
        repeat (400) @(posedge clk);
        apb(1'b0, 8'h08, 32'h0);
        chk({31'h0, (rdata >= 32'h9) && (rdata <= 32'hB)}, 32'h1);
        chk({31'h0, wdogPulse}, 32'h0);
        conclude();
    end
endmodule : watchdog_with_reset_flags_tb
